/* File: core/pcs_pkg.sv */
// constants, field layouts and carrier types of the process speed controller
package pcs_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned SAMPLE_US = 1000;
   localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_US;
   // integral time counts in 0.1 s, derivative time in 0.01 s
   localparam int unsigned INT_UNIT_US = 100_000;
   localparam int unsigned DER_UNIT_US = 10_000;
   localparam int unsigned INT_SCALE = INT_UNIT_US / SAMPLE_US;
   localparam int unsigned DER_SCALE = DER_UNIT_US / SAMPLE_US;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_SELECTOR = 6'h00;
   localparam logic [5:0] OFF_BAND = 6'h04;
   localparam logic [5:0] OFF_INTEGRAL = 6'h08;
   localparam logic [5:0] OFF_UPPER = 6'h0c;
   localparam logic [5:0] OFF_LOWER = 6'h10;
   localparam logic [5:0] OFF_SET_POINT = 6'h14;
   localparam logic [5:0] OFF_DERIV = 6'h18;
   localparam logic [5:0] OFF_CONTROL = 6'h1c;
   localparam logic [5:0] OFF_STATUS = 6'h20;
   localparam logic [5:0] OFF_SPEED = 6'h24;

   // ***************************************************************
   // fields and codes
   // ***************************************************************
   localparam int SETTING_OFF_BIT = 16;
   localparam int CTRL_PANEL_BIT = 0;
   localparam logic [7:0] CODE_DEV_REV = 8'h0a;
   localparam logic [7:0] CODE_DEV_FWD = 8'h0b;
   localparam logic [7:0] CODE_MEAS_REV = 8'h1e;
   localparam logic [7:0] CODE_MEAS_FWD = 8'h1f;
   localparam logic [1:0] DRV_STOP = 2'h0;
   localparam logic [1:0] DRV_FWD = 2'h1;
   localparam logic [1:0] DRV_REV = 2'h2;

   // ***************************************************************
   // ranges (percent in 0.1 %, times in their own units)
   // ***************************************************************
   localparam logic [15:0] BAND_MIN = 16'h0001;
   localparam logic [15:0] BAND_MAX = 16'h2710;
   localparam logic [15:0] INT_MIN = 16'h0001;
   localparam logic [15:0] INT_MAX = 16'h8ca0;
   localparam logic [15:0] DER_MIN = 16'h0001;
   localparam logic [15:0] DER_MAX = 16'h03e8;
   localparam logic [15:0] PCT_MAX = 16'h03e8;
   localparam int unsigned GAIN_SCALE = 1000;
   localparam logic signed [47:0] SPEED_MAX = 48'sh0000_0000_03e8;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_SELECTOR = 8'h0a;
   localparam logic [16:0] RST_BAND = 17'h003e8;
   localparam logic [16:0] RST_INTEGRAL = 17'h0000a;
   localparam logic [16:0] RST_UPPER = 17'h10000;
   localparam logic [16:0] RST_LOWER = 17'h10000;
   localparam logic [15:0] RST_SET_POINT = 16'h0000;
   localparam logic [16:0] RST_DERIV = 17'h10000;
   localparam logic RST_PANEL = 1'b0;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic off;
      logic [15:0] value;
   } pcs_setting_t;

   typedef struct packed {
      logic dir;
      logic lower;
      logic upper;
      logic active;
   } pcs_status_t;

endpackage : pcs_pkg

/* File: core/pcs_sync.sv */
// two-flop synchroniser for a level arriving from a pin
`timescale 1ns/10ps
module pcs_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   logic meta;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : pcs_sync

/* File: core/pcs_divider.sv */
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module pcs_divider #(
   parameter int NW = 48,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic [NW-1:0] quo,
   output logic done
);
   logic [DW:0] rem;
   logic [NW-1:0] shreg;
   logic [DW-1:0] dreg;
   logic [6:0] count;
   logic busy;
   logic [DW:0] trial;

   always_comb begin
      trial = {rem[DW-1:0], shreg[NW-1]};
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busy <= 1'b0;
         done <= 1'b0;
         rem <= '0;
         shreg <= '0;
         dreg <= '0;
         count <= 7'h00;
         quo <= '0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            rem <= '0;
            shreg <= num;
            dreg <= den;
            count <= 7'(NW);
         end else if (busy) begin
            // a zero divisor yields all ones; the caller never passes one
            if (trial >= {1'b0, dreg}) begin
               rem <= trial - {1'b0, dreg};
               shreg <= {shreg[NW-2:0], 1'b1};
            end else begin
               rem <= trial;
               shreg <= {shreg[NW-2:0], 1'b0};
            end
            count <= count - 7'h01;
            if (count == 7'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
               quo <= {shreg[NW-2:0], (trial >= {1'b0, dreg})};
            end
         end
      end
   end
endmodule : pcs_divider

/* File: core/pcs_controller.sv */
// process PID speed controller: settings registers, error, terms, limits
`timescale 1ns/10ps
// Operation
// - only selector codes 10, 11, 30, 31 are accepted and enable control
// - codes 10/11: feedback input is the error itself
// - codes 30/31: feedback is measured value, set point comes separately
// - error is set point minus measured value
// - band spans 0.1 to 1000 %; off value removes the proportional term
// - integral time 0.1 to 3600 s, default 1 s; off removes integral term
// - derivative time 0.01 to 10 s, default off; off removes derivative
// - output is the sum of enabled terms
// - reverse action: positive error raises the speed command
// - forward action: negative error raises the speed command
// - codes 10 and 30 are reverse action, 11 and 31 forward
// - proportional gain is the reciprocal of the band
// - control runs only while selection input is on, else normal speed
// - direction output high in forward rotation, low in reverse or stop; code also holds it low while control is off
// - codes 30/31: upper flag when measured value exceeds upper limit; code raises it only while control runs
// - codes 30/31: lower flag when measured value falls below lower limit; code raises it only while control runs
// - panel operation uses a stored set point of 0 to 100 %
module pcs_controller #(
   parameter int unsigned SAMPLE_COUNT = pcs_pkg::SAMPLE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [5:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic pid_select_input,
   input wire logic [1:0] drive_state,
   input wire logic signed [15:0] feedback_in,
   input wire logic [15:0] set_point_in,
   input wire logic signed [15:0] base_speed,
   output logic signed [15:0] speed_cmd,
   output logic pid_active,
   output logic pid_direction_output,
   output logic upper_limit_flag,
   output logic lower_limit_flag
);
   typedef enum logic [1:0] {ST_IDLE, ST_DIV_P, ST_DIV_I, ST_SUM} pcs_state_t;

   function automatic logic in_span(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      in_span = (v >= lo) && (v <= hi);
   endfunction : in_span

   function automatic logic signed [47:0] clamp(input logic signed [47:0] v, input logic signed [47:0] lim);
      if (v > lim) begin
         clamp = lim;
      end else if (v < -lim) begin
         clamp = -lim;
      end else begin
         clamp = v;
      end
   endfunction : clamp

   // ***************************************************************
   // settings registers
   // ***************************************************************
   logic [7:0] pid_action_selector;
   pcs_pkg::pcs_setting_t proportional_band_setting;
   pcs_pkg::pcs_setting_t integral_time_setting;
   pcs_pkg::pcs_setting_t upper_limit_setting;
   pcs_pkg::pcs_setting_t lower_limit_setting;
   pcs_pkg::pcs_setting_t derivative_time_setting;
   logic [15:0] panel_set_point;
   logic use_panel;
   logic [15:0] wval;
   logic woff;

   assign wval = wdata[15:0];
   assign woff = wdata[pcs_pkg::SETTING_OFF_BIT];

   always_ff @(posedge clk) begin
      if (reset) begin
         pid_action_selector <= pcs_pkg::RST_SELECTOR;
      end else if (wr && addr == pcs_pkg::OFF_SELECTOR) begin
         case (wdata[7:0])
            pcs_pkg::CODE_DEV_REV, pcs_pkg::CODE_DEV_FWD,
            pcs_pkg::CODE_MEAS_REV, pcs_pkg::CODE_MEAS_FWD: pid_action_selector <= wdata[7:0];
            default: pid_action_selector <= pid_action_selector;
         endcase
      end
   end

   // out-of-span writes are ignored so the divisors never reach zero
   always_ff @(posedge clk) begin
      if (reset) begin
         proportional_band_setting <= pcs_pkg::RST_BAND;
         integral_time_setting <= pcs_pkg::RST_INTEGRAL;
         derivative_time_setting <= pcs_pkg::RST_DERIV;
      end else if (wr) begin
         if (addr == pcs_pkg::OFF_BAND && (woff || in_span(wval, pcs_pkg::BAND_MIN, pcs_pkg::BAND_MAX))) begin
            proportional_band_setting <= {woff, wval};
         end
         if (addr == pcs_pkg::OFF_INTEGRAL && (woff || in_span(wval, pcs_pkg::INT_MIN, pcs_pkg::INT_MAX))) begin
            integral_time_setting <= {woff, wval};
         end
         if (addr == pcs_pkg::OFF_DERIV && (woff || in_span(wval, pcs_pkg::DER_MIN, pcs_pkg::DER_MAX))) begin
            derivative_time_setting <= {woff, wval};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         upper_limit_setting <= pcs_pkg::RST_UPPER;
         lower_limit_setting <= pcs_pkg::RST_LOWER;
         panel_set_point <= pcs_pkg::RST_SET_POINT;
         use_panel <= pcs_pkg::RST_PANEL;
      end else if (wr) begin
         if (addr == pcs_pkg::OFF_UPPER && (woff || wval <= pcs_pkg::PCT_MAX)) begin
            upper_limit_setting <= {woff, wval};
         end
         if (addr == pcs_pkg::OFF_LOWER && (woff || wval <= pcs_pkg::PCT_MAX)) begin
            lower_limit_setting <= {woff, wval};
         end
         if (addr == pcs_pkg::OFF_SET_POINT && wval <= pcs_pkg::PCT_MAX) begin
            panel_set_point <= wval;
         end
         if (addr == pcs_pkg::OFF_CONTROL) begin
            use_panel <= wdata[pcs_pkg::CTRL_PANEL_BIT];
         end
      end
   end

   // ***************************************************************
   // mode decode and error
   // ***************************************************************
   logic select_sync;
   logic meas_mode;
   logic forward_action;
   logic enabled;
   logic signed [16:0] err;
   logic signed [16:0] set_point;

   pcs_sync u_select_sync (
      .clk(clk),
      .reset(reset),
      .din(pid_select_input),
      .dout(select_sync)
   );

   assign meas_mode = pid_action_selector == pcs_pkg::CODE_MEAS_REV
      || pid_action_selector == pcs_pkg::CODE_MEAS_FWD;
   assign forward_action = pid_action_selector == pcs_pkg::CODE_DEV_FWD
      || pid_action_selector == pcs_pkg::CODE_MEAS_FWD;
   assign enabled = select_sync;
   assign set_point = use_panel ? $signed({1'b0, panel_set_point}) : $signed({1'b0, set_point_in});
   // deviation modes take the input as the error; measured modes subtract
   assign err = meas_mode ? set_point - 17'(feedback_in) : 17'(feedback_in);

   // ***************************************************************
   // sampled term computation
   // ***************************************************************
   pcs_state_t state;
   logic [16:0] tick;
   logic div_start;
   logic [47:0] div_num;
   logic [31:0] div_den;
   logic [47:0] div_quo;
   logic div_done;
   logic signed [47:0] p_term;
   logic signed [47:0] p_prev;
   logic signed [47:0] i_acc;
   logic signed [47:0] i_lim;
   logic signed [47:0] i_next_acc;
   logic signed [47:0] i_term;
   logic signed [47:0] d_term;
   logic signed [47:0] next_sum;
   logic signed [16:0] err_hold;
   logic neg_hold;
   logic i_wait;
   logic signed [47:0] p_used;

   pcs_divider #(.NW(48), .DW(32)) u_divider (
      .clk(clk),
      .reset(reset),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .quo(div_quo),
      .done(div_done)
   );

   // anti-windup bound keeps the integral term within full speed
   assign i_lim = $signed(48'(integral_time_setting.value) * 48'(pcs_pkg::INT_SCALE)) * pcs_pkg::SPEED_MAX;
   assign i_next_acc = clamp(i_acc + p_term, i_lim);
   assign d_term = derivative_time_setting.off ? 48'sh0
      : (p_term - p_prev) * $signed(48'(derivative_time_setting.value) * 48'(pcs_pkg::DER_SCALE));
   assign next_sum = clamp(p_used + i_term + d_term, pcs_pkg::SPEED_MAX);

   always_ff @(posedge clk) begin
      if (reset || !enabled || tick == 17'(SAMPLE_COUNT - 1)) begin
         tick <= 17'h00000;
      end else begin
         tick <= tick + 17'h00001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_IDLE;
         div_start <= 1'b0;
         div_num <= '0;
         div_den <= '0;
         err_hold <= '0;
         neg_hold <= 1'b0;
         p_term <= '0;
         p_prev <= '0;
         i_acc <= '0;
         i_term <= '0;
         i_wait <= 1'b0;
      end else if (!enabled) begin
         state <= ST_IDLE;
         div_start <= 1'b0;
         p_term <= '0;
         p_prev <= '0;
         i_acc <= '0;
         i_term <= '0;
         i_wait <= 1'b0;
      end else begin
         div_start <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (tick == 17'(SAMPLE_COUNT - 1)) begin
                  err_hold <= err;
                  p_prev <= p_term;
                  neg_hold <= err[16];
                  // gain is the band's reciprocal, 100 % band giving unity
                  div_num <= 48'(err[16] ? -err : err) * 48'(pcs_pkg::GAIN_SCALE);
                  div_den <= proportional_band_setting.off ? 32'h0000_03e8 : 32'(proportional_band_setting.value);
                  div_start <= 1'b1;
                  state <= ST_DIV_P;
               end
            end
            ST_DIV_P: begin
               if (div_done) begin
                  // a removed P term still feeds I and D at unity gain
                  p_term <= neg_hold ? -$signed(div_quo) : $signed(div_quo);
                  state <= ST_DIV_I;
               end
            end
            ST_DIV_I: begin
               if (integral_time_setting.off) begin
                  i_acc <= '0;
                  i_term <= '0;
                  i_wait <= 1'b0;
                  state <= ST_SUM;
               end else if (!i_wait) begin
                  // own flag: the divisor may equal the band, so it cannot mark a started divide
                  i_acc <= i_next_acc;
                  neg_hold <= i_next_acc[47];
                  div_num <= i_next_acc[47] ? 48'(-i_next_acc) : 48'(i_next_acc);
                  div_den <= 32'(integral_time_setting.value) * 32'(pcs_pkg::INT_SCALE);
                  div_start <= 1'b1;
                  i_wait <= 1'b1;
               end else if (div_done) begin
                  i_term <= neg_hold ? -$signed(div_quo) : $signed(div_quo);
                  i_wait <= 1'b0;
                  state <= ST_SUM;
               end
            end
            ST_SUM: begin
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign p_used = proportional_band_setting.off ? 48'sh0 : p_term;

   always_ff @(posedge clk) begin
      if (reset) begin
         speed_cmd <= '0;
         pid_active <= 1'b0;
      end else if (!enabled) begin
         speed_cmd <= base_speed;
         pid_active <= 1'b0;
      end else begin
         pid_active <= 1'b1;
         if (state == ST_SUM) begin
            // reverse action follows the error, forward action opposes it
            speed_cmd <= forward_action ? -16'(next_sum) : 16'(next_sum);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pid_direction_output <= 1'b0;
         upper_limit_flag <= 1'b0;
         lower_limit_flag <= 1'b0;
      end else begin
         pid_direction_output <= enabled && drive_state == pcs_pkg::DRV_FWD;
         upper_limit_flag <= enabled && meas_mode && !upper_limit_setting.off
            && feedback_in > $signed({1'b0, upper_limit_setting.value});
         lower_limit_flag <= enabled && meas_mode && !lower_limit_setting.off
            && feedback_in < $signed({1'b0, lower_limit_setting.value});
      end
   end

   // ***************************************************************
   // register read port
   // ***************************************************************
   pcs_pkg::pcs_status_t status;

   assign status = '{dir: pid_direction_output, lower: lower_limit_flag, upper: upper_limit_flag, active: pid_active};

   always_ff @(posedge clk) begin
      if (reset || !rd) begin
         rdata <= 32'h0000_0000;
      end else begin
         case (addr)
            pcs_pkg::OFF_SELECTOR: rdata <= {24'h000000, pid_action_selector};
            pcs_pkg::OFF_BAND: rdata <= {15'h0000, proportional_band_setting};
            pcs_pkg::OFF_INTEGRAL: rdata <= {15'h0000, integral_time_setting};
            pcs_pkg::OFF_UPPER: rdata <= {15'h0000, upper_limit_setting};
            pcs_pkg::OFF_LOWER: rdata <= {15'h0000, lower_limit_setting};
            pcs_pkg::OFF_SET_POINT: rdata <= {16'h0000, panel_set_point};
            pcs_pkg::OFF_DERIV: rdata <= {15'h0000, derivative_time_setting};
            pcs_pkg::OFF_CONTROL: rdata <= {31'h00000000, use_panel};
            pcs_pkg::OFF_STATUS: rdata <= {28'h0000000, status};
            pcs_pkg::OFF_SPEED: rdata <= {{16{speed_cmd[15]}}, speed_cmd};
            default: rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : pcs_controller

/* File: sim/pcs_chk.sv */
// port assertions for the process speed controller
`timescale 1ns/10ps
module pcs_chk #(
   parameter int unsigned SAMPLE_COUNT = 300
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic rd,
   input wire logic [1:0] drive_state,
   input wire logic signed [15:0] base_speed,
   input wire logic pid_select_input,
   input wire logic [31:0] rdata,
   input wire logic signed [15:0] speed_cmd,
   input wire logic pid_active,
   input wire logic pid_direction_output,
   input wire logic upper_limit_flag,
   input wire logic lower_limit_flag
);
   // ****************
   // checks
   // ****************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   int unsigned since;
   // cycles since the speed command last moved while active
   always_ff @(posedge clk) begin
      if (reset || !pid_active || $changed(speed_cmd)) begin
         since <= 0;
      end else if (since < SAMPLE_COUNT) begin
         since <= since + 1;
      end
   end
   sequence pin_on_s;
      $rose(pid_select_input) ##0 pid_select_input [*3];
   endsequence
   sequence pin_off_s;
      $fell(pid_select_input) ##0 !pid_select_input [*3];
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside answer cycle");
   pass_through_a: assert property (!pid_active && !$past(pid_active) && !$past(reset)
      |-> speed_cmd == $past(base_speed)) else $error("normal speed not passed");
   dir_follow_a: assert property (!$past(reset) |-> pid_direction_output ==
      (pid_active && $past(drive_state) == pcs_pkg::DRV_FWD)) else $error("direction wrong");
   flags_active_a: assert property ((upper_limit_flag || lower_limit_flag) |-> pid_active)
      else $error("limit flag while control off");
   speed_clamp_a: assert property (pid_active && $past(pid_active)
      |-> speed_cmd <= 16'sh03e8 && speed_cmd >= -16'sh03e8) else $error("speed out of range");
   sample_gap_a: assert property (pid_active && $past(pid_active, 2) && $changed(speed_cmd)
      |-> since >= SAMPLE_COUNT - 1) else $error("speed moved between samples");
   select_on_a: assert property (pin_on_s |=> pid_active)
      else $error("selection not taken");
   select_off_a: assert property (pin_off_s |=> !pid_active)
      else $error("selection not dropped");
endmodule : pcs_chk

bind pcs_controller pcs_chk #(.SAMPLE_COUNT(SAMPLE_COUNT)) pcs_chk_inst (.clk, .reset, .rd, .drive_state,
   .base_speed, .pid_select_input, .rdata, .speed_cmd, .pid_active, .pid_direction_output,
   .upper_limit_flag, .lower_limit_flag);

/* File: sim/pcs_plant.sv */
// process sensor and drive loop model at the controller's far side
`timescale 1ns/10ps
module pcs_plant (
   input wire logic clk,
   input wire logic reset,
   input wire logic hold,
   input wire logic signed [15:0] hold_value,
   input wire logic signed [15:0] speed_cmd,
   output logic signed [15:0] feedback_in,
   output logic [1:0] drive_state
);
   // ****************
   // process
   // ****************
   // slow lag, so the loop has a real process to chase
   always_ff @(posedge clk) begin
      if (reset) begin
         feedback_in <= 16'sh0;
      end else if (hold) begin
         feedback_in <= hold_value;
      end else begin
         feedback_in <= feedback_in + ((speed_cmd - feedback_in) >>> 6);
      end
   end
   always_ff @(posedge clk) begin
      if (reset || speed_cmd == 16'sh0) begin
         drive_state <= pcs_pkg::DRV_STOP;
      end else begin
         drive_state <= speed_cmd[15] ? pcs_pkg::DRV_REV : pcs_pkg::DRV_FWD;
      end
   end
endmodule : pcs_plant

/* File: sim/tb_process_pid_speed_controller.sv */
// self-checking bench for the process speed controller
`timescale 1ns/10ps
module tb_process_pid_speed_controller;
   typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e;} pcs_wr_t;
   localparam int unsigned SC = 300;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pid_select_input = 1'b0;
   logic hold = 1'b1;
   logic signed [15:0] hold_value = 16'sh0;
   logic [15:0] set_point_in = 16'h0;
   logic signed [15:0] base_speed = 16'sh0;
   logic [31:0] rdata;
   logic signed [15:0] speed_cmd, feedback_in;
   logic [1:0] drive_state;
   logic pid_active, pid_direction_output, upper_limit_flag, lower_limit_flag;
   int fail_count = 0;
   int compares = 0;
   int seed = 32'h24e8978d;
   logic [31:0] rst_tab [9] = '{32'h0a, 32'h3e8, 32'h0a, 32'h10000, 32'h10000, 32'h0, 32'h10000, 32'h0, 32'h0};
   logic [7:0] codes [4] = '{8'h0a, 8'h0b, 8'h1e, 8'h1f};
   pcs_wr_t wtab [18] = '{'{6'h00, 32'h1f, 32'h1f}, '{6'h00, 32'h0c, 32'h1f}, '{6'h00, 32'h0b, 32'h0b},
      '{6'h00, 32'h1e, 32'h1e}, '{6'h04, 32'h0, 32'h3e8}, '{6'h04, 32'h2711, 32'h3e8},
      '{6'h04, 32'h2710, 32'h2710}, '{6'h04, 32'h1, 32'h1}, '{6'h04, 32'h10000, 32'h10000},
      '{6'h08, 32'h8ca1, 32'h0a}, '{6'h08, 32'h8ca0, 32'h8ca0}, '{6'h08, 32'h10000, 32'h10000},
      '{6'h18, 32'h3e9, 32'h10000}, '{6'h18, 32'h3e8, 32'h3e8}, '{6'h18, 32'h10000, 32'h10000},
      '{6'h0c, 32'h3e9, 32'h10000}, '{6'h0c, 32'h258, 32'h258}, '{6'h10, 32'hc8, 32'hc8}};
   always #10 clk = ~clk;
   pcs_controller #(.SAMPLE_COUNT(SC)) pcs_controller_inst (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
      .pid_select_input, .drive_state, .feedback_in, .set_point_in, .base_speed, .speed_cmd, .pid_active,
      .pid_direction_output, .upper_limit_flag, .lower_limit_flag);
   pcs_plant pcs_plant_inst (.clk, .reset, .hold, .hold_value, .speed_cmd, .feedback_in, .drive_state);
   // ****************
   // helpers
   // ****************
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk
   function automatic int exp_cmd(int err, int band, logic fwd);
      int v;
      v = err * 1000 / band;
      v = (v > 1000) ? 1000 : ((v < -1000) ? -1000 : v);
      return fwd ? -v : v;
   endfunction : exp_cmd
   // ****************
   // tests
   // ****************
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      $display("ERROR %0t: run did not finish", $time);
      end_of_test();
   end
   initial begin
      logic [7:0] code;
      int band, sp, meas, err;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) rd_chk(6'(i * 4), rst_tab[i]);
      rd_chk(6'h28, 32'h0);
      $display("reset values done");
      for (int i = 0; i < 18; i++) begin
         wr_reg(wtab[i].a, wtab[i].d);
         rd_chk(wtab[i].a, wtab[i].e);
      end
      wr_reg(pcs_pkg::OFF_SELECTOR, 32'($unsigned($random(seed)) % 9 + 1));
      rd_chk(pcs_pkg::OFF_SELECTOR, 32'h1e);
      $display("settings done");
      for (int k = 0; k < 8; k++) begin
         code = codes[k % 4];
         band = 100 + $unsigned($random(seed)) % 1900;
         sp = $unsigned($random(seed)) % 1001;
         meas = $random(seed) % 1001;
         wr_reg(pcs_pkg::OFF_SELECTOR, 32'(code));
         wr_reg(pcs_pkg::OFF_BAND, 32'(band));
         wr_reg(pcs_pkg::OFF_CONTROL, 32'(k / 4));
         wr_reg(pcs_pkg::OFF_SET_POINT, 32'(sp));
         // panel trials leave the pin at zero so the stored value must win
         set_point_in <= (k < 4) ? 16'(sp) : 16'h0;
         hold_value <= 16'(meas);
         pid_select_input <= 1'b1;
         repeat (SC + 160) @(posedge clk);
         err = code[4] ? sp - meas : meas;
         chk(32'(speed_cmd), 32'(exp_cmd(err, band, code[0])));
         chk(32'(upper_limit_flag), 32'(code[4] && meas > 600));
         chk(32'(lower_limit_flag), 32'(code[4] && meas < 200));
         chk(32'(pid_direction_output), 32'(drive_state == pcs_pkg::DRV_FWD));
         base_speed <= 16'($random(seed) % 1001);
         pid_select_input <= 1'b0;
         repeat (6) @(posedge clk);
         chk(32'(speed_cmd), 32'(base_speed));
         chk(32'(pid_active), 32'h0);
         $display("trial %0d done", k);
      end
      wr_reg(pcs_pkg::OFF_BAND, 32'h10000);
      wr_reg(pcs_pkg::OFF_SELECTOR, 32'h0a);
      hold_value <= 16'sd500;
      pid_select_input <= 1'b1;
      repeat (SC + 160) @(posedge clk);
      chk(32'(speed_cmd), 32'h0);
      wr_reg(pcs_pkg::OFF_BAND, 32'h3e8);
      wr_reg(pcs_pkg::OFF_INTEGRAL, 32'h0a);
      wr_reg(pcs_pkg::OFF_SELECTOR, 32'h1e);
      wr_reg(pcs_pkg::OFF_CONTROL, 32'h0);
      set_point_in <= 16'd500;
      hold_value <= 16'sd0;
      // constant error: the integral must lift the command past the proportional part
      repeat (20 * SC) @(posedge clk);
      chk(32'(speed_cmd > 16'sd500 && speed_cmd <= 16'sd520), 32'h1);
      hold <= 1'b0;
      repeat (20 * SC) @(posedge clk);
      chk(32'(pid_active), 32'h1);
      $display("closed loop done");
      end_of_test();
   end
endmodule : tb_process_pid_speed_controller
